// >>> rtl/alarm_level_pkg.sv
package alarm_level_pkg;

  // ----------------------------------------------------------------------
  // Data and bus widths
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_MODE = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_MASK = 6'h02;
  localparam logic [5:0] IDX_STATE = 6'h03;
  localparam logic [5:0] IDX_SELECT = 6'h1E;
  localparam logic [5:0] IDX_LOW_TRIG = 6'h1F;
  localparam logic [5:0] IDX_LOW_OUT = 6'h20;
  localparam logic [5:0] IDX_HIGH_TRIG = 6'h21;
  localparam logic [5:0] IDX_HIGH_OUT = 6'h22;

  localparam logic [7:0] ADDR_MODE = {IDX_MODE, 2'h0};
  localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
  localparam logic [7:0] ADDR_MASK = {IDX_MASK, 2'h0};
  localparam logic [7:0] ADDR_STATE = {IDX_STATE, 2'h0};
  localparam logic [7:0] ADDR_SELECT = {IDX_SELECT, 2'h0};
  localparam logic [7:0] ADDR_LOW_TRIG = {IDX_LOW_TRIG, 2'h0};
  localparam logic [7:0] ADDR_LOW_OUT = {IDX_LOW_OUT, 2'h0};
  localparam logic [7:0] ADDR_HIGH_TRIG = {IDX_HIGH_TRIG, 2'h0};
  localparam logic [7:0] ADDR_HIGH_OUT = {IDX_HIGH_OUT, 2'h0};

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MODE_ALARM_EN = 0;
  localparam int MODE_LEVEL_EN = 1;
  localparam int MODE_CURRENT_EN = 2;
  localparam int MODE_VOLTAGE_EN = 3;
  localparam int MODE_BITS = 4;

  localparam int SEL_ALARM_MSB = 7;
  localparam int SEL_ALARM_LSB = 5;
  localparam int SEL_LEVEL_MSB = 6;
  localparam int SEL_LEVEL_LSB = 5;

  localparam int EV_ALARM_LOW = 0;
  localparam int EV_ALARM_HIGH = 1;
  localparam int EV_LEVEL_CHANGE = 2;
  localparam int EV_BITS = 3;

  localparam int ST_ALARM_LOW = 0;
  localparam int ST_ALARM_HIGH = 1;
  localparam int ST_LEVEL_LSB = 2;
  localparam int ST_LEVEL_MSB = 3;
  localparam int ST_ALARM_ACTIVE = 4;
  localparam int ST_LEVEL_ACTIVE = 5;

  // ----------------------------------------------------------------------
  // Source codes of the selector fields
  // ----------------------------------------------------------------------
  localparam logic [2:0] SRC_TEMPERATURE = 3'h0;
  localparam logic [2:0] SRC_AMPLIFIER = 3'h1;
  localparam logic [2:0] SRC_GAIN = 3'h2;
  localparam logic [2:0] SRC_VOLTAGE = 3'h3;
  localparam logic [2:0] SRC_LINE0 = 3'h4;
  localparam logic [2:0] SRC_LINE1 = 3'h5;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_LEVEL = 2'h0;

  typedef enum logic [1:0] {
    FUNC_OFF,
    FUNC_ALARM,
    FUNC_LEVEL
  } func_mode_t;

endpackage

// >>> rtl/band_compare.sv
`timescale 1ns/1ps

module band_compare #(
  parameter int WIDTH = 8
)
(
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] bound1,
  input wire logic [WIDTH-1:0] bound2,
  input wire logic [WIDTH-1:0] bound3,
  output logic [2:0] reached,
  output logic aboveTop
);

  logic [WIDTH-1:0] bounds [3];

  if (WIDTH < 1)
  begin : g_width_check
    $error("band_compare needs a positive width.");
  end

  assign bounds[0] = bound1;
  assign bounds[1] = bound2;
  assign bounds[2] = bound3;

  // ----------------------------------------------------------------------
  // One at-or-above comparator per boundary, plus a strict above comparator on the top boundary
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++)
  begin : g_bound
    assign reached[i] = (value >= bounds[i]);
  end

  assign aboveTop = (value > bound3);

endmodule // band_compare

// >>> rtl/alarm_level_steering.sv
`timescale 1ns/1ps

// Behaviour
// - Three selector bits pick the alarm input from six internal sources.
// - Two selector bits pick the level input from the four analog outputs.
// - Both selectors share one control byte, read per the active mode.
// - With current and voltage output both enabled the alarm stays inactive.
// - Low alarm is on while the selected input is below the low trigger.
// - During low alarm the digital output value is the low substitute byte.
// - High alarm is on while the selected input is above the high trigger and not below the low trigger.
// - During high alarm the digital output value is the high substitute byte.
// - Level mode: the code goes from 00 to 01 at the first level byte.
// - Level mode: the code goes from 01 to 10 at the second level byte.
// - Level mode: the code goes from 10 to 11 at the third level byte.
// - With both modes configured, level mode runs and alarm is ignored.
// - The alarm selector is the top three bits of the control byte.

module alarm_level_steering
#(
  parameter int WIDTH = 8
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [alarm_level_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [alarm_level_pkg::APB_DATA_W-1:0] pwdata,
  output logic [alarm_level_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WIDTH-1:0] temperatureOut,
  input wire logic [WIDTH-1:0] amplifierOut,
  input wire logic [WIDTH-1:0] gainOut,
  input wire logic [WIDTH-1:0] voltageModeOut,
  input wire logic [WIDTH-1:0] digitalValueIn,
  input wire logic levelLine0In,
  input wire logic levelLine1In,
  output logic levelLine0Out,
  output logic levelLine0Oe,
  output logic levelLine1Out,
  output logic levelLine1Oe,
  output logic alarmLow,
  output logic alarmHigh,
  output logic [WIDTH-1:0] digitalOutputValue,
  output logic irq
);

  import alarm_level_pkg::*;

  if (WIDTH != DATA_W)
  begin : g_width_check
    $error("Threshold bytes are fixed at eight bits.");
  end

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [MODE_BITS-1:0] modeCtrl;
  logic [MODE_BITS-1:0] next_modeCtrl;
  logic [7:0] selectByte;
  logic [7:0] next_selectByte;
  logic [WIDTH-1:0] lowTrig;
  logic [WIDTH-1:0] next_lowTrig;
  logic [WIDTH-1:0] lowOut;
  logic [WIDTH-1:0] next_lowOut;
  logic [WIDTH-1:0] highTrig;
  logic [WIDTH-1:0] next_highTrig;
  logic [WIDTH-1:0] highOut;
  logic [WIDTH-1:0] next_highOut;
  logic [EV_BITS-1:0] status;
  logic [EV_BITS-1:0] next_status;
  logic [EV_BITS-1:0] mask;
  logic [EV_BITS-1:0] next_mask;
  logic [APB_DATA_W-1:0] next_prdata;
  logic next_pslverr;
  logic [EV_BITS-1:0] readShown;
  logic [EV_BITS-1:0] next_readShown;

  // ----------------------------------------------------------------------
  // Output state
  // ----------------------------------------------------------------------
  logic next_alarmLow;
  logic next_alarmHigh;
  logic [1:0] levelCode;
  logic [1:0] next_levelCode;
  logic levelDrive;
  logic next_levelDrive;
  logic [WIDTH-1:0] next_digitalOutputValue;

  logic setupPhase;
  logic accessPhase;
  logic addrHit;
  func_mode_t funcMode;
  logic [2:0] alarmSel;
  logic [1:0] levelSel;
  logic [WIDTH-1:0] watched;
  logic [2:0] reached;
  logic aboveTop;
  logic rawLow;
  logic rawHigh;
  logic [1:0] rawCode;
  logic [EV_BITS-1:0] events;

  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  // Read data and the error flag are captured in the setup cycle, so the
  // access cycle always completes at once.
  assign pready = 1'b1;

  // ----------------------------------------------------------------------
  // Mode and input selection
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (modeCtrl[MODE_LEVEL_EN])
    begin
      funcMode = FUNC_LEVEL;
    end
    else if (modeCtrl[MODE_ALARM_EN] &&
             !(modeCtrl[MODE_CURRENT_EN] && modeCtrl[MODE_VOLTAGE_EN]))
    begin
      funcMode = FUNC_ALARM;
    end
    else
    begin
      funcMode = FUNC_OFF;
    end
  end

  assign alarmSel = selectByte[SEL_ALARM_MSB:SEL_ALARM_LSB];
  assign levelSel = selectByte[SEL_LEVEL_MSB:SEL_LEVEL_LSB];

  always_comb
  begin
    // The same bits steer one multiplexer whose reading depends on mode.
    watched = '0;
    if (funcMode == FUNC_LEVEL)
    begin
      unique case (levelSel)
        2'h0: watched = temperatureOut;
        2'h1: watched = amplifierOut;
        2'h2: watched = gainOut;
        2'h3: watched = voltageModeOut;
      endcase
    end
    else
    begin
      case (alarmSel)
        SRC_TEMPERATURE: watched = temperatureOut;
        SRC_AMPLIFIER: watched = amplifierOut;
        SRC_GAIN: watched = gainOut;
        SRC_VOLTAGE: watched = voltageModeOut;
        SRC_LINE0: watched = {WIDTH{levelLine0In}};
        SRC_LINE1: watched = {WIDTH{levelLine1In}};
        default: watched = '0;
      endcase
    end
  end

  band_compare #(
    .WIDTH(WIDTH)
  ) u_band (
    .value(watched),
    .bound1(lowTrig),
    .bound2(lowOut),
    .bound3(highTrig),
    .reached(reached),
    .aboveTop(aboveTop)
  );

  // ----------------------------------------------------------------------
  // Alarm and level decision
  // ----------------------------------------------------------------------
  always_comb
  begin
    rawLow = 1'b0;
    rawHigh = 1'b0;
    rawCode = RST_LEVEL;
    // Codes 6 and 7 name no source, so no alarm can fire from them.
    if (funcMode == FUNC_ALARM && alarmSel <= SRC_LINE1)
    begin
      rawLow = !reached[0];
      rawHigh = aboveTop;
    end
    if (funcMode == FUNC_LEVEL)
    begin
      if (reached[2])
      begin
        rawCode = 2'h3;
      end
      else if (reached[1])
      begin
        rawCode = 2'h2;
      end
      else if (reached[0])
      begin
        rawCode = 2'h1;
      end
      else
      begin
        rawCode = 2'h0;
      end
    end
  end

  always_comb
  begin
    next_alarmLow = rawLow;
    next_alarmHigh = rawHigh && !rawLow;
    next_levelCode = rawCode;
    next_levelDrive = (funcMode == FUNC_LEVEL);
    if (rawLow)
    begin
      next_digitalOutputValue = lowOut;
    end
    else if (rawHigh)
    begin
      next_digitalOutputValue = highOut;
    end
    else
    begin
      next_digitalOutputValue = digitalValueIn;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarmLow <= 1'b0;
      alarmHigh <= 1'b0;
      levelCode <= RST_LEVEL;
      levelDrive <= 1'b0;
      digitalOutputValue <= '0;
    end
    else
    begin
      alarmLow <= next_alarmLow;
      alarmHigh <= next_alarmHigh;
      levelCode <= next_levelCode;
      levelDrive <= next_levelDrive;
      digitalOutputValue <= next_digitalOutputValue;
    end
  end

  assign levelLine0Out = levelCode[0];
  assign levelLine1Out = levelCode[1];
  assign levelLine0Oe = levelDrive;
  assign levelLine1Oe = levelDrive;

  // ----------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------
  always_comb
  begin
    events[EV_ALARM_LOW] = next_alarmLow && !alarmLow;
    events[EV_ALARM_HIGH] = next_alarmHigh && !alarmHigh;
    events[EV_LEVEL_CHANGE] = next_levelDrive && levelDrive &&
                              (next_levelCode != levelCode);
  end

  assign irq = |(status & mask);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_comb
  begin
    addrHit = 1'b1;
    next_prdata = '0;
    unique case (paddr)
      ADDR_MODE: next_prdata[MODE_BITS-1:0] = modeCtrl;
      ADDR_STATUS: next_prdata[EV_BITS-1:0] = status;
      ADDR_MASK: next_prdata[EV_BITS-1:0] = mask;
      ADDR_STATE:
      begin
        next_prdata[ST_ALARM_LOW] = alarmLow;
        next_prdata[ST_ALARM_HIGH] = alarmHigh;
        next_prdata[ST_LEVEL_MSB:ST_LEVEL_LSB] = levelCode;
        next_prdata[ST_ALARM_ACTIVE] = (funcMode == FUNC_ALARM);
        next_prdata[ST_LEVEL_ACTIVE] = (funcMode == FUNC_LEVEL);
      end
      ADDR_SELECT: next_prdata[7:0] = selectByte;
      ADDR_LOW_TRIG: next_prdata[WIDTH-1:0] = lowTrig;
      ADDR_LOW_OUT: next_prdata[WIDTH-1:0] = lowOut;
      ADDR_HIGH_TRIG: next_prdata[WIDTH-1:0] = highTrig;
      ADDR_HIGH_OUT: next_prdata[WIDTH-1:0] = highOut;
      default: addrHit = 1'b0;
    endcase
  end

  always_comb
  begin
    next_modeCtrl = modeCtrl;
    next_selectByte = selectByte;
    next_lowTrig = lowTrig;
    next_lowOut = lowOut;
    next_highTrig = highTrig;
    next_highOut = highOut;
    next_mask = mask;
    next_pslverr = pslverr;
    next_readShown = readShown;
    next_status = status;
    if (setupPhase)
    begin
      next_pslverr = !addrHit;
      next_readShown = (paddr == ADDR_STATUS) ? status : '0;
    end
    if (accessPhase && pwrite)
    begin
      unique case (paddr)
        ADDR_MODE: next_modeCtrl = pwdata[MODE_BITS-1:0];
        ADDR_MASK: next_mask = pwdata[EV_BITS-1:0];
        ADDR_SELECT: next_selectByte = pwdata[7:0];
        ADDR_LOW_TRIG: next_lowTrig = pwdata[WIDTH-1:0];
        ADDR_LOW_OUT: next_lowOut = pwdata[WIDTH-1:0];
        ADDR_HIGH_TRIG: next_highTrig = pwdata[WIDTH-1:0];
        ADDR_HIGH_OUT: next_highOut = pwdata[WIDTH-1:0];
        default: next_modeCtrl = modeCtrl;
      endcase
    end
    // Only the bits that the reader actually saw are cleared, so an event
    // landing between setup and access is kept; a new event always wins.
    if (accessPhase && !pwrite && paddr == ADDR_STATUS)
    begin
      next_status = status & ~readShown;
    end
    next_status = next_status | events;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeCtrl <= '0;
      selectByte <= RST_BYTE;
      lowTrig <= '0;
      lowOut <= '0;
      highTrig <= '0;
      highOut <= '0;
      status <= '0;
      mask <= '0;
      prdata <= '0;
      pslverr <= 1'b0;
      readShown <= '0;
    end
    else
    begin
      modeCtrl <= next_modeCtrl;
      selectByte <= next_selectByte;
      lowTrig <= next_lowTrig;
      lowOut <= next_lowOut;
      highTrig <= next_highTrig;
      highOut <= next_highOut;
      status <= next_status;
      mask <= next_mask;
      if (setupPhase)
      begin
        prdata <= next_prdata;
      end
      pslverr <= next_pslverr;
      readShown <= next_readShown;
    end
  end

endmodule // alarm_level_steering

// >>> test/alarm_level_assertions.sv
`timescale 1ns/1ps

module alarm_level_checker
  import alarm_level_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] temperatureOut,
  input wire logic [7:0] amplifierOut,
  input wire logic [7:0] gainOut,
  input wire logic [7:0] voltageModeOut,
  input wire logic [7:0] digitalValueIn,
  input wire logic levelLine0In,
  input wire logic levelLine1In,
  input wire logic levelLine0Out,
  input wire logic levelLine0Oe,
  input wire logic levelLine1Out,
  input wire logic alarmLow,
  input wire logic alarmHigh,
  input wire logic [7:0] digitalOutputValue,
  input wire logic irq
);
  // ------
  // Configuration mirror
  // ------
  // Bus writes are mirrored so that each output can be tied to the exact
  // bytes behind it; bytes the block ignores are mirrored but never used.
  logic [7:0] cfg [35];
  logic [7:0] next_cfg [35];
  logic [7:0] src [8];
  logic [7:0] sel, aVal, lVal, loOut, hiOut;
  logic [1:0] code;
  logic live, armed, levelOn, lowHit, highHit;

  always_comb
  begin
    next_cfg = cfg;
    if (psel && penable && pwrite && paddr[7:2] < 6'h23)
    begin
      next_cfg[paddr[7:2]] = pwdata[7:0];
    end
    src = '{temperatureOut, amplifierOut, gainOut, voltageModeOut,
      {8{levelLine0In}}, {8{levelLine1In}}, 8'h00, 8'h00};
    sel = cfg[IDX_SELECT];
    loOut = cfg[IDX_LOW_OUT];
    hiOut = cfg[IDX_HIGH_OUT];
    aVal = src[sel[7:5]];
    lVal = src[{1'b0, sel[6:5]}];
    levelOn = cfg[IDX_MODE][1];
    armed = cfg[IDX_MODE][0] && !levelOn && !(&cfg[IDX_MODE][3:2]);
    lowHit = armed && sel[7:5] < 3'h6 && aVal < cfg[IDX_LOW_TRIG];
    highHit = armed && sel[7:5] < 3'h6 && aVal > cfg[IDX_HIGH_TRIG];
    code = lVal >= cfg[IDX_HIGH_TRIG] ? 2'h3 : lVal >= loOut ? 2'h2 :
      lVal >= cfg[IDX_LOW_TRIG] ? 2'h1 : 2'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg <= '{default: 8'h00};
      live <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      live <= 1'b1;
    end
  end

  // ------
  // Output relations
  // ------
  // Outputs trail their cause by one edge, so live masks the first edge.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  low_alarm_a: assert property (
    live && $past(lowHit) |-> alarmLow) else $error("low alarm missing");
  high_alarm_a: assert property (
    live && $past(highHit) |-> alarmHigh || alarmLow)
    else $error("high alarm missing");
  alarm_off_a: assert property (
    live && !$past(armed) |-> !alarmLow && !alarmHigh)
    else $error("alarm while disabled");
  alarm_single_a: assert property (
    !(alarmLow && alarmHigh)) else $error("both alarms set");
  low_subst_a: assert property (
    live && alarmLow |-> digitalOutputValue == $past(loOut))
    else $error("wrong low substitute");
  high_subst_a: assert property (
    live && alarmHigh |-> digitalOutputValue == $past(hiOut))
    else $error("wrong high substitute");
  pass_through_a: assert property (
    live && !alarmLow && !alarmHigh |->
    digitalOutputValue == $past(digitalValueIn)) else $error("no pass");
  level_code_a: assert property (
    live && $past(levelOn) |-> levelLine0Oe &&
    {levelLine1Out, levelLine0Out} == $past(code)) else $error("bad code");
  irq_raise_a: assert property (
    $rose(alarmLow) && cfg[IDX_MASK][0] |-> irq) else $error("irq missing");
endmodule // alarm_level_checker

bind alarm_level_steering alarm_level_checker i_check (
  .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .temperatureOut, .amplifierOut, .gainOut, .voltageModeOut,
  .digitalValueIn, .levelLine0In, .levelLine1In, .levelLine0Out,
  .levelLine0Oe, .levelLine1Out, .alarmLow, .alarmHigh,
  .digitalOutputValue, .irq
);

// >>> test/test_alarm_level_steering.sv
`timescale 1ns/1ps

module test_alarm_level_steering;
  import alarm_level_pkg::*;

  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, irq;
  logic [7:0] paddr, temperatureOut, amplifierOut, gainOut, voltageModeOut;
  logic [7:0] digitalValueIn, digitalOutputValue;
  logic [31:0] pwdata, prdata, rd;
  logic levelLine0In, levelLine1In, levelLine0Out, levelLine0Oe;
  logic levelLine1Out, levelLine1Oe, alarmLow, alarmHigh;
  int fail_count, comparisons;
  logic [7:0] regMap [9] = '{ADDR_MODE, ADDR_STATUS, ADDR_MASK, ADDR_STATE,
    ADDR_SELECT, ADDR_LOW_TRIG, ADDR_LOW_OUT, ADDR_HIGH_TRIG, ADDR_HIGH_OUT};
  logic [7:0] bound [4] = '{8'h3F, 8'h40, 8'hC0, 8'hC1};
  logic [9:0] bandOut [4] = '{10'h211, 10'h05A, 10'h05A, 10'h1EE};
  logic [7:0] lvIn [6] = '{8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0};
  logic [1:0] lvCode [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [9:0] alm;
  logic [3:0] lvl;

  assign alm = {alarmLow, alarmHigh, digitalOutputValue};
  assign lvl = {levelLine1Oe, levelLine0Oe, levelLine1Out, levelLine0Out};

  alarm_level_steering #(.WIDTH(8)) i_dut (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .temperatureOut, .amplifierOut, .gainOut,
    .voltageModeOut, .digitalValueIn, .levelLine0In, .levelLine1In,
    .levelLine0Out, .levelLine0Oe, .levelLine1Out, .levelLine1Oe,
    .alarmLow, .alarmHigh, .digitalOutputValue, .irq
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ------
  // Bus and source tasks
  // ------
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want)
    begin
      fail_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, want);
    end
  endtask

  // A selected analog source carries v and a selected line sits at zero; an unselected line sits at all ones.
  task automatic drive(input int s, input logic [7:0] v, input logic [7:0] r);
    @(posedge sys_clk);
    temperatureOut <= s == 0 ? v : r;
    amplifierOut <= s == 1 ? v : r;
    gainOut <= s == 2 ? v : r;
    voltageModeOut <= s == 3 ? v : r;
    levelLine0In <= s != 4;
    levelLine1In <= s != 5;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end

  // ------
  // Sequence
  // ------
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    digitalValueIn = 8'h5A;
    {temperatureOut, amplifierOut, gainOut, voltageModeOut} = 32'h80808080;
    {levelLine0In, levelLine1In} = 2'h3;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (regMap[i])
    begin
      xfer(1'b0, regMap[i], 32'h0);
      cmp({rd[30:0], err}, 32'h0);
    end
    xfer(1'b1, 8'h40, 32'h55);
    xfer(1'b0, 8'h40, 32'h0);
    cmp({rd[30:0], err}, 32'h1);
    xfer(1'b1, ADDR_SELECT, 32'hFFFFFFA0);
    xfer(1'b0, ADDR_SELECT, 32'h0);
    cmp(rd, 32'hA0);
    xfer(1'b1, ADDR_LOW_TRIG, 32'h40);
    xfer(1'b1, ADDR_LOW_OUT, 32'h11);
    xfer(1'b1, ADDR_HIGH_TRIG, 32'hC0);
    xfer(1'b1, ADDR_HIGH_OUT, 32'hEE);
    xfer(1'b1, ADDR_MASK, 32'h1);
    xfer(1'b1, ADDR_MODE, 32'h1);
    for (int s = 0; s < 6; s++)
    begin
      xfer(1'b1, ADDR_SELECT, s << 5);
      drive(s, 8'h20, 8'h80);
      cmp(alm, 10'h211);
    end
    cmp(irq, 1'b1);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    #1;
    cmp({irq, rd[0]}, 2'h1);
    xfer(1'b1, ADDR_MASK, 32'h0);
    xfer(1'b1, ADDR_SELECT, 32'h0);
    foreach (bound[i])
    begin
      drive(0, bound[i], 8'h80);
      cmp(alm, bandOut[i]);
    end
    xfer(1'b0, ADDR_STATUS, 32'h0);
    cmp({irq, rd[1:0]}, 3'h3);
    xfer(1'b1, ADDR_MODE, 32'hD);
    drive(0, 8'h20, 8'h80);
    cmp(alm, 10'h05A);
    xfer(1'b1, ADDR_MODE, 32'h3);
    drive(0, 8'h20, 8'h80);
    cmp({alm, lvl}, 14'h05AE);
    xfer(1'b1, ADDR_LOW_OUT, 32'h80);
    for (int s = 0; s < 4; s++)
    begin
      xfer(1'b1, ADDR_SELECT, (s << 5) | 32'h80);
      foreach (lvIn[i])
      begin
        drive(s, lvIn[i], 8'hFF);
        cmp(lvl, {2'h3, lvCode[i]});
      end
    end
    xfer(1'b0, ADDR_STATUS, 32'h0);
    cmp(rd, 32'h4);
    tally_and_finish();
  end
endmodule // test_alarm_level_steering
